// *** dsr_clk_gate.sv ***
`timescale 1ns/1ps
module dsr_clk_gate
   import dsr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   dsr_gate_if.gate gif
);
   logic en_lat_r;

   // enable sampled on the falling edge so gclk never shows a runt pulse
   always_ff @(negedge ref_clk) begin
      if (srst) begin
         en_lat_r <= 1'b0;
      end else begin
         en_lat_r <= gif.en_req;
      end
   end

   assign gif.en_active = en_lat_r;
   assign gif.gclk = ref_clk & en_lat_r;
endmodule

// *** dsr_gate_if.sv ***
`timescale 1ns/1ps
interface dsr_gate_if;
   logic en_req;
   logic en_active;
   logic gclk;
   modport ctl (output en_req, input en_active, input gclk);
   modport gate (input en_req, output en_active, output gclk);
endinterface

// *** dsr_pkg.sv ***
package dsr_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PORT_N = 5;

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_SW_RESET_ZERO = 12'h040;
   localparam logic [ADDR_W-1:0] OFF_DEEP_GATES = 12'h128;
   localparam logic [ADDR_W-1:0] OFF_RUN_GATES = 12'h108;
   localparam logic [ADDR_W-1:0] OFF_SLEEP_GATES = 12'h118;
   localparam logic [ADDR_W-1:0] OFF_RUN_CLOCK_CFG = 12'h060;
   localparam logic [ADDR_W-1:0] OFF_CAPS_ONE = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h070;

   // reset values
   localparam logic [DATA_W-1:0] RST_SW_RESET_ZERO = 32'h00000000;
   localparam logic [PORT_N-1:0] RST_GATES = 5'h00;
   localparam logic RST_AUTO_GATING = 1'b0;

   // software reset control zero field positions
   localparam int BIT_PWM_RESET = 20;
   localparam int BIT_ADC0_RESET = 16;
   localparam int BIT_WATCHDOG_RESET = 3;
   localparam logic [DATA_W-1:0] SW_RESET_WRITABLE = 32'h00110008;

   // run clock configuration field
   localparam int BIT_AUTO_GATING = 11;

   // status register fields
   localparam int STAT_GATES_LSB = 0;
   localparam int STAT_MODE_LSB = 8;
   localparam int STAT_AUTO_BIT = 12;

   // number of units with reset outputs
   localparam int UNIT_N = 3;

   typedef enum logic [1:0] {
      DSR_MODE_RUN,
      DSR_MODE_SLEEP,
      DSR_MODE_DEEP
   } dsr_mode_t;
endpackage

// *** dsr_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Each writable deep-sleep gate bit is the clock enable of one port while in deep-sleep.
// [RQ2] An access to a port whose clock is gated off answers with a bus fault.
// [RQ3] All gate enable bits reset to zero so every port starts unclocked.
// [RQ4] Separate run, sleep and deep-sleep gate sets exist and the one for the current mode applies.
// [RQ5] Sleep and deep-sleep sets apply only when the auto gating select bit is set.
// [RQ6] Deep-sleep gate bits 0 to 4 enable ports A to E in that order, all read/write.
// [RQ7] Deep-sleep gate bits 31 to 5 are read-only zero; software preserves them.
// [RQ8] Writes to the software reset register are masked by the capabilities register.
// [RQ9] Software reset bit 20 is the read/write reset of the pwm unit, reset zero.
// [RQ10] Software reset bit 16 is the read/write reset of converter unit 0, reset zero.
// [RQ11] Software reset bit 3 is the read/write reset of the watchdog, reset zero.
// [RQ12] The software reset register resets to zero and its other bits read zero.
// [RQ13] A set software reset bit holds its unit in reset; clearing it releases the unit.
// [RQ14] Clock enables reach the ports through a glitch-free gate tied to the system clock.
module dsr_top
   import dsr_pkg::*;
#(
   parameter logic [DATA_W-1:0] CAPS_ONE = 32'h00110008
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [1:0] op_mode,
   input wire logic port_acc_req,
   input wire logic [2:0] port_acc_sel,
   output logic port_acc_ok,
   output logic port_acc_fault,
   output logic [PORT_N-1:0] port_clk_en,
   output logic [PORT_N-1:0] port_gclk,
   output logic pwm_rst_n,
   output logic adc0_rst_n,
   output logic watchdog_rst_n
);
   logic [PORT_N-1:0] run_gates_r;
   logic [PORT_N-1:0] run_gates_nxt;
   logic [PORT_N-1:0] sleep_gates_r;
   logic [PORT_N-1:0] sleep_gates_nxt;
   logic [PORT_N-1:0] deep_gates_r;
   logic [PORT_N-1:0] deep_gates_nxt;
   logic auto_gating_r;
   logic auto_gating_nxt;
   logic [DATA_W-1:0] sw_reset_r;
   logic [DATA_W-1:0] sw_reset_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [PORT_N-1:0] clk_en_r;
   logic [PORT_N-1:0] active_gates;
   logic acc_ok_r;
   logic acc_fault_r;
   logic acc_ok_nxt;
   logic acc_fault_nxt;
   dsr_mode_t mode;

   // address decode
   wire sel_run = (reg_addr == OFF_RUN_GATES);
   wire sel_sleep = (reg_addr == OFF_SLEEP_GATES);
   wire sel_deep = (reg_addr == OFF_DEEP_GATES);
   wire sel_cfg = (reg_addr == OFF_RUN_CLOCK_CFG);
   wire sel_swr = (reg_addr == OFF_SW_RESET_ZERO);
   wire sel_caps = (reg_addr == OFF_CAPS_ONE);
   wire sel_stat = (reg_addr == OFF_STATUS);
   wire wr_run = reg_wr & sel_run;
   wire wr_sleep = reg_wr & sel_sleep;
   wire wr_deep = reg_wr & sel_deep;
   wire wr_cfg = reg_wr & sel_cfg;
   wire wr_swr = reg_wr & sel_swr;

   // only bits that exist on this part and are wired to a unit can change
   wire [DATA_W-1:0] swr_mask = CAPS_ONE & SW_RESET_WRITABLE;

   assign run_gates_nxt = wr_run ? reg_wdata[PORT_N-1:0] : run_gates_r;
   assign sleep_gates_nxt = wr_sleep ? reg_wdata[PORT_N-1:0] : sleep_gates_r;
   assign deep_gates_nxt = wr_deep ? reg_wdata[PORT_N-1:0] : deep_gates_r; // see [RQ6]
   assign auto_gating_nxt = wr_cfg ? reg_wdata[BIT_AUTO_GATING] : auto_gating_r;
   assign sw_reset_nxt = wr_swr ?
      ((sw_reset_r & ~swr_mask) | (reg_wdata & swr_mask)) : sw_reset_r; // see [RQ8]

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         run_gates_r <= RST_GATES; // see [RQ3]
         sleep_gates_r <= RST_GATES; // see [RQ3]
         deep_gates_r <= RST_GATES; // see [RQ3]
         auto_gating_r <= RST_AUTO_GATING;
         sw_reset_r <= RST_SW_RESET_ZERO; // see [RQ12]
      end else begin
         run_gates_r <= run_gates_nxt;
         sleep_gates_r <= sleep_gates_nxt;
         deep_gates_r <= deep_gates_nxt;
         auto_gating_r <= auto_gating_nxt;
         sw_reset_r <= sw_reset_nxt;
      end
   end

   // mode selection; an unknown code is treated as run, the safe choice
   always_comb begin
      case (op_mode)
         2'h1: mode = DSR_MODE_SLEEP;
         2'h2: mode = DSR_MODE_DEEP;
         default: mode = DSR_MODE_RUN;
      endcase
   end

   // without auto gating the run set governs every mode
   wire use_sleep = auto_gating_r & (mode == DSR_MODE_SLEEP); // see [RQ5]
   wire use_deep = auto_gating_r & (mode == DSR_MODE_DEEP); // see [RQ5]
   assign active_gates = use_deep ? deep_gates_r :
                         use_sleep ? sleep_gates_r : run_gates_r; // see [RQ4]

   // registered enable; the gate then re-times it on the falling edge
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         clk_en_r <= RST_GATES;
      end else begin
         clk_en_r <= active_gates; // see [RQ1]
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < PORT_N; gi++) begin : g_gate
         dsr_gate_if gif ();
         assign gif.en_req = clk_en_r[gi];
         assign port_gclk[gi] = gif.gclk;
         dsr_clk_gate u_gate (
            .ref_clk (ref_clk),
            .srst (srst),
            .gif (gif)
         ); // see [RQ14]
      end
   endgenerate

   // port access check; the bus fault is judged on the enable the port really sees
   wire sel_valid = (port_acc_sel < 3'(PORT_N));
   wire sel_clocked = sel_valid & clk_en_r[port_acc_sel];
   assign acc_ok_nxt = port_acc_req & sel_clocked;
   assign acc_fault_nxt = port_acc_req & ~sel_clocked; // see [RQ2]

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         acc_ok_r <= 1'b0;
         acc_fault_r <= 1'b0;
      end else begin
         acc_ok_r <= acc_ok_nxt;
         acc_fault_r <= acc_fault_nxt;
      end
   end

   // unit resets held while the control bit is set
   dsr_unit_reset u_pwm_rst (
      .ref_clk (ref_clk),
      .srst (srst),
      .hold (sw_reset_r[BIT_PWM_RESET]),
      .unit_rst_n (pwm_rst_n)
   ); // see [RQ9] [RQ13]

   dsr_unit_reset u_adc0_rst (
      .ref_clk (ref_clk),
      .srst (srst),
      .hold (sw_reset_r[BIT_ADC0_RESET]),
      .unit_rst_n (adc0_rst_n)
   ); // see [RQ10] [RQ13]

   dsr_unit_reset u_wdog_rst (
      .ref_clk (ref_clk),
      .srst (srst),
      .hold (sw_reset_r[BIT_WATCHDOG_RESET]),
      .unit_rst_n (watchdog_rst_n)
   ); // see [RQ11] [RQ13]

   // read mux; unused and unmapped bits read zero
   wire [DATA_W-1:0] rd_gates_run = {{(DATA_W-PORT_N){1'b0}}, run_gates_r};
   wire [DATA_W-1:0] rd_gates_sleep = {{(DATA_W-PORT_N){1'b0}}, sleep_gates_r};
   wire [DATA_W-1:0] rd_gates_deep = {{(DATA_W-PORT_N){1'b0}}, deep_gates_r}; // see [RQ7]
   wire [DATA_W-1:0] rd_cfg = DATA_W'(auto_gating_r) << BIT_AUTO_GATING;
   wire [DATA_W-1:0] rd_swr = sw_reset_r & SW_RESET_WRITABLE; // see [RQ12]
   wire [DATA_W-1:0] rd_stat = (DATA_W'(clk_en_r) << STAT_GATES_LSB) |
                               (DATA_W'(mode) << STAT_MODE_LSB) |
                               (DATA_W'(auto_gating_r) << STAT_AUTO_BIT);

   assign rdata_nxt = !reg_rd ? '0 :
                      sel_run ? rd_gates_run :
                      sel_sleep ? rd_gates_sleep :
                      sel_deep ? rd_gates_deep :
                      sel_cfg ? rd_cfg :
                      sel_swr ? rd_swr :
                      sel_caps ? CAPS_ONE :
                      sel_stat ? rd_stat : '0;

   // read data stands for one cycle only, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign port_acc_ok = acc_ok_r;
   assign port_acc_fault = acc_fault_r;
   assign port_clk_en = clk_en_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_gates_reset_zero: assert property ( // see [RQ3]
      $fell(srst) |-> (deep_gates_r == RST_GATES) && (clk_en_r == RST_GATES)
         && (sleep_gates_r == RST_GATES) && (run_gates_r == RST_GATES))
      else $error("gate enables not zero after reset");

   a_deep_write_bits: assert property ( // see [RQ6]
      wr_deep |=> deep_gates_r == $past(reg_wdata[PORT_N-1:0]))
      else $error("deep-sleep gate write not stored");

   a_deep_read_upper: assert property ( // see [RQ7]
      (reg_rd && sel_deep) |=> (reg_rdata[DATA_W-1:PORT_N] == '0)
         && (reg_rdata[PORT_N-1:0] == $past(deep_gates_r)))
      else $error("deep-sleep gate read wrong");

   a_swr_write_mask: assert property ( // see [RQ8]
      wr_swr |=> ((sw_reset_r ^ $past(sw_reset_r)) & ~swr_mask) == '0)
      else $error("masked reset bit changed");

   a_swr_read_zero: assert property ( // see [RQ12]
      (reg_rd && sel_swr) |=> (reg_rdata & ~SW_RESET_WRITABLE) == '0)
      else $error("reserved reset bit reads one");

   a_pwm_reset_hold: assert property ( // see [RQ9]
      sw_reset_r[BIT_PWM_RESET] |=> !pwm_rst_n)
      else $error("pwm not held in reset");

   a_adc_reset_hold: assert property ( // see [RQ10]
      sw_reset_r[BIT_ADC0_RESET] |=> !adc0_rst_n)
      else $error("converter not held in reset");

   a_wdog_reset_release: assert property ( // see [RQ11] [RQ13]
      $fell(sw_reset_r[BIT_WATCHDOG_RESET]) |-> !watchdog_rst_n ##1 watchdog_rst_n)
      else $error("watchdog reset not released");

   a_gate_fault_resp: assert property ( // see [RQ2]
      (port_acc_req && !sel_clocked) |=> port_acc_fault && !port_acc_ok)
      else $error("gated port access not faulted");

   a_auto_off_run: assert property ( // see [RQ5]
      !auto_gating_r |-> ##1 (clk_en_r == $past(run_gates_r)))
      else $error("sleep set used without auto gating");

   a_deep_set_used: assert property ( // see [RQ4] [RQ1]
      (auto_gating_r && mode == DSR_MODE_DEEP) |=> clk_en_r == $past(deep_gates_r))
      else $error("deep-sleep set not applied");

   a_gate_follows: assert property ( // see [RQ14]
      $changed(clk_en_r) |-> ##1 (g_gate[0].gif.en_active == clk_en_r[0]))
      else $error("gate enable not re-timed");

   a_sleep_set_used: assert property ( // see [RQ4] [RQ5]
      (auto_gating_r && mode == DSR_MODE_SLEEP) |=> clk_en_r == $past(sleep_gates_r))
      else $error("sleep set not applied");

   a_run_set_used: assert property ( // see [RQ4]
      (mode == DSR_MODE_RUN) |=> clk_en_r == $past(run_gates_r))
      else $error("run set not applied in run mode");

   a_gate_ok_resp: assert property ( // see [RQ2]
      (port_acc_req && sel_clocked) |=> port_acc_ok && !port_acc_fault)
      else $error("clocked port access not accepted");

   a_idle_no_resp: assert property ( // see [RQ2]
      !port_acc_req |=> !port_acc_ok && !port_acc_fault)
      else $error("port response without request");

   a_swr_write_store: assert property ( // see [RQ8]
      wr_swr |=> (sw_reset_r & swr_mask) == ($past(reg_wdata) & swr_mask))
      else $error("writable reset bit not stored");

   a_swr_reserved_zero: assert property ( // see [RQ12]
      (sw_reset_r & ~SW_RESET_WRITABLE) == '0)
      else $error("reserved reset bit held one");

   a_pwm_reset_release: assert property ( // see [RQ9] [RQ13]
      !sw_reset_r[BIT_PWM_RESET] |=> pwm_rst_n)
      else $error("pwm reset not released");

   a_adc_reset_release: assert property ( // see [RQ10] [RQ13]
      !sw_reset_r[BIT_ADC0_RESET] |=> adc0_rst_n)
      else $error("converter reset not released");

   a_wdog_reset_hold: assert property ( // see [RQ11]
      sw_reset_r[BIT_WATCHDOG_RESET] |=> !watchdog_rst_n)
      else $error("watchdog not held in reset");

   a_caps_read_value: assert property ( // see [RQ8]
      (reg_rd && sel_caps) |=> reg_rdata == CAPS_ONE)
      else $error("capabilities read wrong");

   a_rdata_idle_zero: assert property ( // see [RQ7]
      !reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside a read");
endmodule

// *** dsr_unit_model.sv ***
`timescale 1ns/1ps
module dsr_unit_model
   import dsr_pkg::*;
(
   input wire logic clr,
   input wire logic [PORT_N-1:0] port_gclk,
   output logic [8*PORT_N-1:0] edges
);
   logic [7:0] cnt [PORT_N];
   for (genvar i = 0; i < PORT_N; i++) begin : g_unit
      // a port only advances on its own gated clock
      always @(posedge port_gclk[i] or posedge clr) begin
         if (clr) begin
            cnt[i] <= 8'h00;
         end else begin
            cnt[i] <= cnt[i] + 8'h01;
         end
      end
      assign edges[8*i +: 8] = cnt[i];
   end
endmodule

// *** dsr_unit_reset.sv ***
`timescale 1ns/1ps
module dsr_unit_reset
   import dsr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic hold,
   output logic unit_rst_n
);
   logic rst_n_r;
   logic rst_n_nxt;

   // system reset also resets the unit, not only the software bit
   assign rst_n_nxt = ~(hold | srst);

   always_ff @(posedge ref_clk) begin
      rst_n_r <= rst_n_nxt;
   end

   assign unit_rst_n = rst_n_r;
endmodule

// *** test_deep_sleep_gating_and_soft_reset.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %0h seen %0h", nm, e, s); end end
module test_deep_sleep_gating_and_soft_reset;
   import dsr_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 12'h000;
   logic [DATA_W-1:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [1:0] op_mode = 2'h0;
   logic port_acc_req = 1'b0;
   logic [2:0] port_acc_sel = 3'h0;
   logic port_acc_ok, port_acc_fault, pwm_rst_n, adc0_rst_n, watchdog_rst_n;
   logic [PORT_N-1:0] port_clk_en, port_gclk, en_x;
   logic clr = 1'b0;
   logic [8*PORT_N-1:0] edges;
   logic [31:0] seed = 32'h4212516C;
   logic [31:0] r, s, d, v, q, e;
   int checked = 0;
   int n_mismatch = 0;
   dsr_top DUT (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .op_mode, .port_acc_req, .port_acc_sel, .port_acc_ok, .port_acc_fault,
      .port_clk_en, .port_gclk, .pwm_rst_n, .adc0_rst_n, .watchdog_rst_n);
   dsr_unit_model units (.clr, .port_gclk, .edges);
   always #20 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [4:0] exp_en(input logic [1:0] m, input logic ag,
      input logic [4:0] rg, input logic [4:0] sg, input logic [4:0] dg);
      if (ag && m == 2'h2) return dg;
      if (ag && m == 2'h1) return sg;
      return rg;
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] dt);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= dt;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] dt);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 dt = reg_rdata;
   endtask
   task automatic acc(input logic [2:0] sl);
      logic ok;
      @(posedge ref_clk);
      port_acc_req <= 1'b1;
      port_acc_sel <= sl;
      @(posedge ref_clk);
      port_acc_req <= 1'b0;
      ok = (sl < 3'h5) && en_x[sl];
      #1 `CHK("port access", {ok, ~ok}, {port_acc_ok, port_acc_fault})
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      #1 `CHK("clk_en after reset", 5'h00, port_clk_en)
      @(posedge ref_clk);
      #1 `CHK("unit resets", 3'h7, {pwm_rst_n, adc0_rst_n, watchdog_rst_n})
      rd(OFF_SW_RESET_ZERO, q);
      `CHK("sw reset init", 32'h00000000, q)
      rd(OFF_DEEP_GATES, q);
      `CHK("deep gates init", 32'h00000000, q)
      rd(OFF_CAPS_ONE, q);
      `CHK("capabilities", 32'h00110008, q)
      rd(12'h0FC, q);
      `CHK("unmapped", 32'h00000000, q)
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         r = seed;
         seed = xs(seed);
         s = seed;
         seed = xs(seed);
         d = (k == 7) ? 32'hFFFFFFFF : seed;
         wr(OFF_RUN_GATES, r);
         wr(OFF_SLEEP_GATES, s);
         wr(OFF_DEEP_GATES, d);
         wr(OFF_RUN_CLOCK_CFG, 32'(k[2]) << BIT_AUTO_GATING);
         op_mode <= k[1:0];
         rd(OFF_DEEP_GATES, q);
         `CHK("deep gates", d & 32'h0000001F, q)
         // rewrite what was read, keeping the reserved bits as found
         wr(OFF_DEEP_GATES, q);
         en_x = exp_en(k[1:0], k[2], r[4:0], s[4:0], d[4:0]);
         repeat (3) @(posedge ref_clk);
         #1 `CHK("clk_en", en_x, port_clk_en)
         @(negedge ref_clk) clr = 1'b1;
         #1 clr = 1'b0;
         repeat (10) @(posedge ref_clk);
         @(negedge ref_clk);
         for (int i = 0; i < PORT_N; i++) begin
            `CHK("gated edges", en_x[i] ? 8'h0A : 8'h00, edges[8*i +: 8])
         end
         for (int i = 0; i < 8; i++) begin
            acc(3'(i));
         end
         rd(OFF_RUN_GATES, q);
         `CHK("run gates", r & 32'h0000001F, q)
         rd(OFF_SLEEP_GATES, q);
         `CHK("sleep gates", s & 32'h0000001F, q)
         rd(OFF_RUN_CLOCK_CFG, q);
         `CHK("auto gating", 32'(k[2]) << BIT_AUTO_GATING, q)
         rd(OFF_STATUS, q);
         // mode code 3 runs on the run set and reports run
         e = (32'(k[2]) << STAT_AUTO_BIT) | (32'(en_x) << STAT_GATES_LSB);
         e = e | (32'((k[1:0] == 2'h3) ? 2'h0 : k[1:0]) << STAT_MODE_LSB);
         `CHK("status", e, q)
      end
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         v = (k == 0) ? 32'hFFFFFFFF : seed;
         wr(OFF_SW_RESET_ZERO, v);
         rd(OFF_SW_RESET_ZERO, q);
         e = v & SW_RESET_WRITABLE & 32'h00110008;
         `CHK("sw reset reg", e, q)
         `CHK("pwm reset", ~e[20], pwm_rst_n)
         `CHK("adc0 reset", ~e[16], adc0_rst_n)
         `CHK("watchdog reset", ~e[3], watchdog_rst_n)
      end
      srst <= 1'b1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      srst <= 1'b0;
      rd(OFF_SW_RESET_ZERO, q);
      `CHK("sw reset after reset", 32'h00000000, q)
      rd(OFF_DEEP_GATES, q);
      `CHK("deep gates after reset", 32'h00000000, q)
      `CHK("clk_en after second reset", 5'h00, port_clk_en)
      `CHK("units after reset", 3'h7, {pwm_rst_n, adc0_rst_n, watchdog_rst_n})
      complete_run();
   end
endmodule
